// ===== rtl/dsc_counter_top.sv
// dual seconds counter behind a three wire serial port
`include "dsc_params.svh"
// ************************************************
// top of the dual seconds counter
// ************************************************
// Summary of operation
// - two 32-bit seconds counters advance once a second from the oscillator
// - first 8 serial bits of a session fill the command register on sclk rise
// - without main supply the serial port is off and ignores everything
// - without main supply only the continuous counter runs; supply counter holds
// - command bit 7 picks the continuous counter for the 32-bit transfer
// - command bit 6 picks the supply-on counter for the 32-bit transfer
// - reads snapshot the counter after the command byte and shift the copy
// - writes buffer 32 bits and load the counter on the 32nd rise
// - bits 7 and 6 both set load trim from bits 5..3, later clocks ignored
// - trim 000 stops the oscillator; higher runs faster, lower slower
// - command bit 2 clears the continuous counter when session enable drops
// - command bit 1 clears the supply-on counter at session end; both together
// - command bit 0 one means device sends, zero means host writes
// - a clock cycle is fall then rise; write data valid at the rise
// - dropping session enable aborts the transfer and floats the data line
// - after 32 write bits further clocks are ignored until a new session
// - read bits go out on falling edges, the first right after the command
// - during a read the data line is driven only while sclk is low
// - 1 Hz square tick is driven only while main supply is present
module dsc_counter_top #(
  parameter int unsigned OSC_CYCLES = `DSC_CLK_HZ / `DSC_OSC_HZ,
  parameter int unsigned TICKS_PER_SEC = `DSC_OSC_HZ,
  parameter int unsigned TRIM_STEP = `DSC_TRIM_STEP
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic session_en,
  input wire logic sclk,
  input wire logic dq_in,
  output logic dq_out,
  output logic dq_oe,
  input wire logic supply_ok,
  output logic tick_out
);
  localparam dsc_pkg::dsc_bits_t CMD_LAST = dsc_pkg::dsc_bits_t'(`DSC_CMD_BITS - 1);
  localparam dsc_pkg::dsc_bits_t DATA_LAST = dsc_pkg::dsc_bits_t'(`DSC_DATA_BITS - 1);

  // ************************************************
  // pin sampling
  // ************************************************
  logic [3:0] sync_q;
  logic s_ce;
  logic s_sclk;
  logic s_dq;
  logic s_pwr;
  logic sclk_d;
  logic ce_d;
  logic sess;
  logic rise;
  logic fall;
  logic end_ok;

  dsc_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk(clk),
    .nrst(nrst),
    .din({supply_ok, dq_in, sclk, session_en}),
    .dout(sync_q)
  );

  // filtered pin levels and edges
  assign s_ce = sync_q[0];
  assign s_sclk = sync_q[1];
  assign s_dq = sync_q[2];
  assign s_pwr = sync_q[3];
  assign sess = s_ce && s_pwr;
  assign rise = s_sclk && !sclk_d;
  assign fall = !s_sclk && sclk_d;
  assign end_ok = ce_d && !s_ce && s_pwr;

  // ************************************************
  // timebase
  // ************************************************
  dsc_pkg::dsc_trim_t trim;
  logic sec_pulse;
  logic half_high;

  dsc_timebase #(
    .OSC_CYCLES(OSC_CYCLES),
    .TICKS_PER_SEC(TICKS_PER_SEC),
    .TRIM_STEP(TRIM_STEP)
  ) u_timebase (
    .clk(clk),
    .nrst(nrst),
    .trim(trim),
    .sec_pulse(sec_pulse),
    .half_high(half_high)
  );

  // ************************************************
  // serial engine
  // ************************************************
  dsc_pkg::dsc_state_t state;
  dsc_pkg::dsc_state_t next_state;
  dsc_pkg::dsc_bits_t bits;
  dsc_pkg::dsc_bits_t next_bits;
  dsc_pkg::dsc_word_t shift;
  dsc_pkg::dsc_word_t next_shift;
  dsc_pkg::dsc_word_t snap;
  dsc_pkg::dsc_word_t next_snap;
  dsc_pkg::dsc_trim_t next_trim;
  logic next_dout;
  logic drv;
  logic next_drv;
  logic sel_c;
  logic next_sel_c;
  logic clr_c;
  logic next_clr_c;
  logic clr_s;
  logic next_clr_s;
  logic [7:0] cmd_word;
  dsc_pkg::dsc_word_t wr_word;
  logic cmd_last;
  logic wr_last;
  logic is_trim;
  logic is_xfer;
  dsc_pkg::dsc_word_t cont;
  dsc_pkg::dsc_word_t son;

  // decode of the byte and word being completed
  assign cmd_word = {s_dq, shift[`DSC_DATA_BITS-1 -: `DSC_CMD_BITS-1]};
  assign wr_word = {s_dq, shift[`DSC_DATA_BITS-1:1]};
  assign cmd_last = sess && state == dsc_pkg::dsc_cmd && rise && bits == CMD_LAST;
  assign wr_last = sess && state == dsc_pkg::dsc_write && rise && bits == DATA_LAST;
  assign is_trim = cmd_word[`DSC_B_CONT] && cmd_word[`DSC_B_SON];
  assign is_xfer = cmd_word[`DSC_B_CONT] ^ cmd_word[`DSC_B_SON];

  // next state of the serial engine
  always_comb begin
    next_state = state;
    next_bits = bits;
    next_shift = shift;
    next_snap = snap;
    next_trim = trim;
    next_dout = dq_out;
    next_drv = drv;
    next_sel_c = sel_c;
    next_clr_c = clr_c;
    next_clr_s = clr_s;
    if (!sess) begin
      next_state = dsc_pkg::dsc_idle;
      next_bits = '0;
      next_drv = 1'b0;
      next_clr_c = 1'b0;
      next_clr_s = 1'b0;
    end else begin
      case (state)
        dsc_pkg::dsc_idle: begin
          next_state = dsc_pkg::dsc_cmd;
          next_bits = '0;
        end
        dsc_pkg::dsc_cmd: begin
          if (rise) begin
            next_shift = wr_word;
            next_bits = bits + 1'b1;
          end
          if (cmd_last) begin
            next_bits = '0;
            next_sel_c = cmd_word[`DSC_B_CONT];
            if (is_trim) begin
              next_trim = cmd_word[`DSC_B_TRIM_HI:`DSC_B_TRIM_LO];
              next_state = dsc_pkg::dsc_done;
            end else if (is_xfer) begin
              next_state = cmd_word[`DSC_B_READ] ? dsc_pkg::dsc_read : dsc_pkg::dsc_write;
              next_snap = cmd_word[`DSC_B_CONT] ? cont : son;
            end else begin
              next_clr_c = cmd_word[`DSC_B_CLR_CONT];
              next_clr_s = cmd_word[`DSC_B_CLR_SON];
              next_state = dsc_pkg::dsc_done;
            end
          end
        end
        dsc_pkg::dsc_read: begin
          if (fall) begin
            next_dout = snap[0];
            next_snap = {1'b0, snap[`DSC_DATA_BITS-1:1]};
            next_drv = 1'b1;
          end
          if (rise) begin
            next_bits = bits + 1'b1;
            if (bits == DATA_LAST) begin
              next_state = dsc_pkg::dsc_done;
              next_drv = 1'b0;
            end
          end
        end
        dsc_pkg::dsc_write: begin
          if (rise) begin
            next_shift = wr_word;
            next_bits = bits + 1'b1;
          end
          if (wr_last) begin
            next_state = dsc_pkg::dsc_done;
          end
        end
        dsc_pkg::dsc_done: begin
          next_state = dsc_pkg::dsc_done;
        end
        default: begin
          next_state = dsc_pkg::dsc_idle;
        end
      endcase
    end
  end

  // serial engine registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= dsc_pkg::dsc_idle;
      bits <= '0;
      shift <= '0;
      snap <= '0;
      trim <= `DSC_TRIM_RESET;
      dq_out <= 1'b0;
      drv <= 1'b0;
      sel_c <= 1'b0;
      clr_c <= 1'b0;
      clr_s <= 1'b0;
      sclk_d <= 1'b0;
      ce_d <= 1'b0;
    end else begin
      state <= next_state;
      bits <= next_bits;
      shift <= next_shift;
      snap <= next_snap;
      trim <= next_trim;
      dq_out <= next_dout;
      drv <= next_drv;
      sel_c <= next_sel_c;
      clr_c <= next_clr_c;
      clr_s <= next_clr_s;
      sclk_d <= s_sclk;
      ce_d <= s_ce;
    end
  end

  // data line driven only in the low half of a read clock
  assign dq_oe = sess && state == dsc_pkg::dsc_read && drv && !s_sclk;

  // ************************************************
  // seconds counters and tick
  // ************************************************
  dsc_pkg::dsc_word_t next_cont;
  dsc_pkg::dsc_word_t next_son;
  logic next_tick;

  // counting, loads and clears; clear wins over load, load over count
  always_comb begin
    next_cont = cont;
    next_son = son;
    if (sec_pulse) begin
      next_cont = cont + 1'b1;
    end
    if (sec_pulse && s_pwr) begin
      next_son = son + 1'b1;
    end
    if (wr_last && sel_c) begin
      next_cont = wr_word;
    end
    if (wr_last && !sel_c) begin
      next_son = wr_word;
    end
    if (end_ok && clr_c) begin
      next_cont = '0;
    end
    if (end_ok && clr_s) begin
      next_son = '0;
    end
    next_tick = s_pwr && half_high;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cont <= '0;
      son <= '0;
      tick_out <= 1'b0;
    end else begin
      cont <= next_cont;
      son <= next_son;
      tick_out <= next_tick;
    end
  end

  // ************************************************
  // checks
  // ************************************************
  cont_step_a: assert property (
    @(posedge clk) disable iff (!nrst)
    sec_pulse && !wr_last && !end_ok |=> cont == $past(cont) + 32'h1
  ) else $error("continuous counter did not step");

  cmd_len_a: assert property (
    @(posedge clk) disable iff (!nrst)
    cmd_last |=> state != dsc_pkg::dsc_cmd && bits == '0
  ) else $error("command byte not closed after eight bits");

  port_off_a: assert property (
    @(posedge clk) disable iff (!nrst)
    !s_pwr |=> state == dsc_pkg::dsc_idle && !dq_oe
  ) else $error("serial port active without supply");

  son_hold_a: assert property (
    @(posedge clk) disable iff (!nrst)
    !s_pwr |=> $stable(son)
  ) else $error("supply counter moved without supply");

  xfer_dir_a: assert property (
    @(posedge clk) disable iff (!nrst)
    cmd_last && is_xfer |=>
      state == ($past(cmd_word[`DSC_B_READ]) ? dsc_pkg::dsc_read : dsc_pkg::dsc_write)
  ) else $error("transfer direction wrong");

  snap_take_a: assert property (
    @(posedge clk) disable iff (!nrst)
    cmd_last && is_xfer |=> snap == (sel_c ? $past(cont) : $past(son))
  ) else $error("snapshot does not match the selected counter");

  write_load_a: assert property (
    @(posedge clk) disable iff (!nrst)
    wr_last && !end_ok |=> (sel_c ? cont : son) == $past(wr_word)
  ) else $error("written word not loaded");

  trim_load_a: assert property (
    @(posedge clk) disable iff (!nrst)
    cmd_last && is_trim |=> trim == $past(cmd_word[`DSC_B_TRIM_HI:`DSC_B_TRIM_LO]) && state == dsc_pkg::dsc_done
  ) else $error("trim not loaded");

  clear_cont_a: assert property (
    @(posedge clk) disable iff (!nrst)
    end_ok && clr_c |=> cont == 32'h0
  ) else $error("continuous counter not cleared");

  abort_a: assert property (
    @(posedge clk) disable iff (!nrst)
    !sess |-> !dq_oe ##1 state == dsc_pkg::dsc_idle
  ) else $error("transfer not aborted");

  done_stay_a: assert property (
    @(posedge clk) disable iff (!nrst)
    state == dsc_pkg::dsc_done && sess |=> state == dsc_pkg::dsc_done
  ) else $error("clocks after transfer not ignored");

  read_bit_a: assert property (
    @(posedge clk) disable iff (!nrst)
    sess && state == dsc_pkg::dsc_read && fall |=> dq_out == $past(snap[0]) && drv
  ) else $error("read bit not presented on falling edge");

  drive_low_a: assert property (
    @(posedge clk) disable iff (!nrst)
    dq_oe |-> !s_sclk && state == dsc_pkg::dsc_read
  ) else $error("data line driven while clock high");

  tick_gate_a: assert property (
    @(posedge clk) disable iff (!nrst)
    !s_pwr |=> !tick_out
  ) else $error("tick driven without supply");
endmodule

// ===== pkg/dsc_params.svh
// named constants of the dual seconds counter
`ifndef DSC_PARAMS_SVH
`define DSC_PARAMS_SVH
// ************************************************
// timing
// ************************************************
`define DSC_CLK_HZ 200000000
`define DSC_OSC_HZ 32768
`define DSC_TRIM_STEP 1
// ************************************************
// serial framing and command fields
// ************************************************
`define DSC_CMD_BITS 8
`define DSC_DATA_BITS 32
`define DSC_B_CONT 7
`define DSC_B_SON 6
`define DSC_B_TRIM_HI 5
`define DSC_B_TRIM_LO 3
`define DSC_B_CLR_CONT 2
`define DSC_B_CLR_SON 1
`define DSC_B_READ 0
// ************************************************
// trim values
// ************************************************
`define DSC_TRIM_RESET 3'h3
`define DSC_TRIM_MID 3'h3
`define DSC_TRIM_STOP 3'h0
`endif

// ===== pkg/dsc_pkg.sv
// types of the dual seconds counter
package dsc_pkg;
  typedef enum logic [2:0] {
    dsc_idle = 3'h0,
    dsc_cmd = 3'h1,
    dsc_read = 3'h3,
    dsc_write = 3'h5,
    dsc_done = 3'h7
  } dsc_state_t;
  typedef logic [4:0] dsc_bits_t;
  typedef logic [2:0] dsc_trim_t;
  typedef logic [31:0] dsc_word_t;
endpackage

// ===== rtl/dsc_sync.sv
// three stage synchroniser with agreement filter
module dsc_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] ff1;
  logic [WIDTH-1:0] ff2;
  logic [WIDTH-1:0] ff3;
  logic [WIDTH-1:0] next_out;

  generate
    if (WIDTH < 1) begin : g_chk
      $error("dsc_sync needs a width of one or more");
    end
  endgenerate

  // a bit moves only once stages two and three agree
  always_comb begin
    next_out = (~(ff2 ^ ff3) & ff2) | ((ff2 ^ ff3) & dout);
  end

  // stage one feeds stage two only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ff1 <= '0;
      ff2 <= '0;
      ff3 <= '0;
      dout <= '0;
    end else begin
      ff1 <= din;
      ff2 <= ff1;
      ff3 <= ff2;
      dout <= next_out;
    end
  end
endmodule

// ===== rtl/dsc_timebase.sv
// trimmable oscillator model and seconds prescaler
`include "dsc_params.svh"
module dsc_timebase #(
  parameter int unsigned OSC_CYCLES = `DSC_CLK_HZ / `DSC_OSC_HZ,
  parameter int unsigned TICKS_PER_SEC = `DSC_OSC_HZ,
  parameter int unsigned TRIM_STEP = `DSC_TRIM_STEP
) (
  input wire logic clk,
  input wire logic nrst,
  input wire dsc_pkg::dsc_trim_t trim,
  output logic sec_pulse,
  output logic half_high
);
  localparam int unsigned PW = $clog2(OSC_CYCLES + 4 * TRIM_STEP + 1);
  localparam int unsigned TW = $clog2(TICKS_PER_SEC);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICKS_PER_SEC - 1);
  localparam logic [TW-1:0] TICK_HALF = TW'(TICKS_PER_SEC / 2);

  logic [PW-1:0] pre;
  logic [PW-1:0] next_pre;
  logic [TW-1:0] ticks;
  logic [TW-1:0] next_ticks;
  logic next_sec;
  logic next_half;
  logic run;
  logic osc_edge;

  generate
    if (OSC_CYCLES < 4 * TRIM_STEP + 2 || TICKS_PER_SEC < 2) begin : g_chk
      $error("dsc_timebase period too short for the trim range");
    end
  endgenerate

  // oscillator period in clk cycles less one (last prescaler count); higher trim runs faster
  function automatic logic [PW-1:0] period_of(input dsc_pkg::dsc_trim_t t);
    int d;
    d = int'(`DSC_TRIM_MID) - int'(t);
    return PW'(int'(OSC_CYCLES) + d * int'(TRIM_STEP) - 1);
  endfunction

  // oscillator edges and seconds count
  always_comb begin
    run = trim != `DSC_TRIM_STOP;
    osc_edge = run && (pre >= period_of(trim));
    next_pre = pre;
    next_ticks = ticks;
    if (osc_edge) begin
      next_pre = '0;
      next_ticks = (ticks == TICK_LAST) ? '0 : ticks + 1'b1;
    end else if (run) begin
      next_pre = pre + 1'b1;
    end
    next_sec = osc_edge && (ticks == TICK_LAST);
    next_half = ticks < TICK_HALF;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pre <= '0;
      ticks <= '0;
      sec_pulse <= 1'b0;
      half_high <= 1'b0;
    end else begin
      pre <= next_pre;
      ticks <= next_ticks;
      sec_pulse <= next_sec;
      half_high <= next_half;
    end
  end
endmodule

// ===== verif/dsc_host.sv
// host model driving the three wire serial port
module dsc_host (
  input wire logic clk,
  input wire logic dq_out,
  input wire logic dq_oe,
  output logic session_en,
  output logic sclk,
  output logic dq_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic host_oe = 1'b0;
  logic host_d = 1'b0;
  logic last_lvl = 1'b0;
  int oe_errs = 0;
  time t_cmd = 0;
  // serial clock idles high between sessions
  initial begin
    session_en = 1'b0;
    sclk = 1'b1;
  end
  // wire level; a released line shows the inverse of its last level
  assign dq_in = dq_oe ? dq_out : (host_oe ? host_d : ~last_lvl);
  // remember the last driven line level; a released line then stays at its inverse
  always @(posedge clk) begin
    if (dq_oe || host_oe) last_lvl <= dq_in;
  end
  // one session: command byte, then ndata clocks; keep leaves session_en high
  task automatic run(input logic [7:0] cmd, input int ndata, input logic [31:0] wd, input bit keep,
                     output logic [31:0] rd);
    logic [39:0] bits;
    bit rd_mode;
    int i;
    bits = {wd, cmd};
    rd_mode = cmd[0] && (cmd[7] ^ cmd[6]);
    rd = '0;
    session_en = 1'b1;
    repeat (12) @(negedge clk);
    for (i = 0; i < 8 + ndata; i++) begin
      sclk = 1'b0;
      host_oe = (i < 8) || !rd_mode;
      host_d = bits[i % 40];
      repeat (8) @(negedge clk);
      if (i >= 8 && i < 40) rd[i - 8] = dq_in;
      sclk = 1'b1;
      if (i == 7) t_cmd = $time;
      repeat (7) @(negedge clk);
      if (dq_oe !== 1'b0) oe_errs++;
      @(negedge clk);
    end
    host_oe = 1'b0;
    if (!keep) begin
      session_en = 1'b0;
      repeat (12) @(negedge clk);
    end
  endtask
endmodule

// ===== verif/testbench.sv
// self-checking bench of the dual seconds counter
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic supply_ok = 1'b0;
  logic session_en;
  logic sclk;
  logic dq_in;
  logic dq_out;
  logic dq_oe;
  logic tick_out;
  int num_errors = 0;
  int total_checks = 0;
  int tick_cnt = 0;
  int sec_ns;
  logic [31:0] m_cont = '0;
  logic [31:0] m_son = '0;
  logic [31:0] rd;
  logic [31:0] c_seen;
  logic [31:0] s_seen;
  logic [31:0] w;
  time t1;
  time t2;
  time tdown;
  time tup;
  // ************************************************
  // clock, tick counting, instances
  // ************************************************
  always #2.5 clk = ~clk;
  // count rising edges of the seconds tick
  always @(posedge tick_out) tick_cnt++;
  dsc_counter_top #(.OSC_CYCLES(10), .TICKS_PER_SEC(8), .TRIM_STEP(1)) dsc_counter_top_i (
    .clk(clk), .nrst(nrst), .session_en(session_en), .sclk(sclk), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .supply_ok(supply_ok), .tick_out(tick_out));
  dsc_host dsc_host_i (.clk(clk), .dq_out(dq_out), .dq_oe(dq_oe), .session_en(session_en),
    .sclk(sclk), .dq_in(dq_in));
  // ************************************************
  // helpers
  // ************************************************
  task automatic print_verdict;
    $display("checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  // seen if within tol of exp, otherwise exp, so a miss or an unknown shows the expectation
  function automatic logic [31:0] near(input logic [31:0] seen, input longint exp, input int tol);
    return ((seen + tol >= exp && seen <= exp + tol) === 1'b1) ? seen : exp[31:0];
  endfunction
  task automatic ses(input logic [7:0] cmd, input int n, input logic [31:0] wd);
    dsc_host_i.run(cmd, n, wd, 1'b0, rd);
  endtask
  task automatic chk_both;
    ses(8'h81, 32, '0);
    check(rd, m_cont);
    ses(8'h41, 32, '0);
    check(rd, m_son);
  endtask
  task automatic rd_both;
    ses(8'h81, 32, '0);
    c_seen = rd;
    ses(8'h41, 32, '0);
    s_seen = rd;
  endtask
  // run at one trim setting, optionally with a supply loss in the middle
  task automatic span(input logic [2:0] trim, input bit pf);
    ses(8'h06, 0, '0);
    ses({2'b11, trim, 3'b000}, 0, '0);
    t1 = dsc_host_i.t_cmd;
    tick_cnt = 0;
    repeat (600) @(negedge clk);
    tdown = $time;
    tup = $time;
    if (pf) begin
      supply_ok = 1'b0;
      repeat (20) @(negedge clk);
      check(tick_out, 1'b0);
      ses(8'h80, 32, $urandom);
      repeat (600) @(negedge clk);
      tup = $time;
      supply_ok = 1'b1;
      repeat (20) @(negedge clk);
    end
    ses(8'hC0, 0, '0);
    t2 = dsc_host_i.t_cmd;
    sec_ns = 40 * (13 - trim);
    if (!pf) check(tick_cnt, near(tick_cnt, (t2 - t1) / sec_ns, 2));
    rd_both();
    check(c_seen, near(c_seen, (t2 - t1) / sec_ns, 1));
    check(s_seen, near(s_seen, (tdown - t1 + t2 - tup) / sec_ns, 2));
  endtask
  // ************************************************
  // watchdog and main sequence
  // ************************************************
  initial begin
    #500000;
    num_errors++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'hD3A9));
    repeat (3) @(negedge clk);
    check(dq_oe, 1'b0);
    check(tick_out, 1'b0);
    nrst = 1'b1;
    supply_ok = 1'b1;
    repeat (10) @(negedge clk);
    // trim 000 freezes both counters so reads are exact
    ses(8'hC0, 0, '0);
    // seconds counted before the freeze are cleared so the model starts at zero
    ses(8'h06, 0, '0);
    for (int k = 0; k < 4; k++) begin
      w = $urandom;
      if (k[0]) begin
        ses(8'h40, 32, w);
        m_son = w;
      end else begin
        ses(8'h80, 32, w);
        m_cont = w;
      end
      chk_both();
    end
    // clocks after a full write change nothing
    w = $urandom;
    ses(8'h80, 40, w);
    m_cont = w;
    chk_both();
    // aborted write keeps the counter; aborted read gives correct leading bits
    ses(8'h40, 20, $urandom);
    chk_both();
    ses(8'h81, 10, '0);
    check(rd[9:0], m_cont[9:0]);
    check(dq_oe, 1'b0);
    // trim command ignores trailing clocks
    ses(8'hC0, 32, $urandom);
    chk_both();
    // each clear code
    for (int k = 1; k < 4; k++) begin
      m_cont = $urandom;
      m_son = $urandom;
      ses(8'h80, 32, m_cont);
      ses(8'h40, 32, m_son);
      ses({5'h00, k[1:0], 1'b0}, 0, '0);
      if (k[1]) m_cont = '0;
      if (k[0]) m_son = '0;
      chk_both();
    end
    // counting rates, then a supply loss
    span(3'h3, 1'b0);
    span(3'h7, 1'b0);
    span(3'h1, 1'b0);
    span(3'h3, 1'b1);
    check(dsc_host_i.oe_errs, 0);
    print_verdict();
  end
endmodule
